//--- hdl/cdo_output_ctrl_regs.sv
// Notes on behaviour
// - Force-absent keeps mute or offset applied unless force-present is set
// - Force-present never mutes nor adds offset
// - Status bit always shows true input state
// - Gating clear: power-down from bits and enable
// - Gating set, enable low: both outputs down
// - Gating set, enable high: loss powers down
// - Mute-select zero: loss adds small offset
// - Mute-select one: loss mutes the output
// - Signal present: outputs run normally unless forced
// - Channel-0 bits 2:0 hold slow threshold top
// - Output-1 bits 7:5 hold fast threshold top
// - Output-1 bits 4:0 set output-1 swing
// - Control-1 bit 7 is fast threshold low bit
// - Control-1 bit 6 is slow threshold low bit
// - Control-1 bits 2:0 hold slow threshold top
// - Power-down bit downs its output, enable low overrides
// - Rate bit picks threshold, pin high forces slow
`timescale 1ns/1ps
`default_nettype none
module cdo_output_ctrl_regs #(
    parameter logic [6:0] SLAVE_ADDR = 7'h5b
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Serial management bus, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output var logic sda_out,
    output var logic sda_oe,
    // Device pins
    input wire logic enable_pin,
    input wire logic rate_pin,
    input wire logic signal_present,
    // Output stage controls
    output var cdo_pkg::cdo_chan_out_t ch0_out,
    output var cdo_pkg::cdo_chan_out_t ch1_out
);
    typedef struct packed {
        cdo_pkg::cdo_smb_state_t state;
        logic scl_q;
        logic sda_q;
        logic [7:0] shreg;
        logic [3:0] cnt;
        logic [7:0] ptr;
        logic rw;
        logic oe;
        logic sda_o;
        logic sig;
        logic [7:0] mode;
        logic [7:0] lsb;
        logic [7:0] out0;
        logic [7:0] ch0ctl;
        logic [7:0] out1;
        logic [7:0] ch1ctl;
    } cdo_regs_st_t;

    cdo_regs_st_t st_ff;
    cdo_regs_st_t nxt_st;
    cdo_pkg::cdo_chan_cfg_t ch0_cfg;
    cdo_pkg::cdo_chan_cfg_t ch1_cfg;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] rd_data;

    ////////////////////////////////////////////////////////////////////////
    // Read decode, unmapped offsets read as zero
    function automatic logic [7:0] rd_reg(input logic [7:0] a, input cdo_regs_st_t s);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            cdo_pkg::ADR_STATUS: d[cdo_pkg::B_SIGNAL] = s.sig;
            cdo_pkg::ADR_MODE: d = s.mode;
            cdo_pkg::ADR_LSB: d = s.lsb;
            cdo_pkg::ADR_OUT0: d = s.out0;
            cdo_pkg::ADR_CH0CTL: d = s.ch0ctl;
            cdo_pkg::ADR_OUT1: d = s.out1;
            cdo_pkg::ADR_CH1CTL: d = s.ch1ctl;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // Bus events from sampled lines
    assign scl_rise = scl_in && !st_ff.scl_q;
    assign scl_fall = !scl_in && st_ff.scl_q;
    assign bus_start = scl_in && st_ff.scl_q && st_ff.sda_q && !sda_in;
    assign bus_stop = scl_in && st_ff.scl_q && !st_ff.sda_q && sda_in;
    assign rd_data = rd_reg(st_ff.ptr, st_ff);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave and register writes
    always_comb begin
        nxt_st = st_ff;
        nxt_st.scl_q = scl_in;
        nxt_st.sda_q = sda_in;
        nxt_st.sig = signal_present;
        nxt_st.sda_o = 1'b0;
        if (bus_start) begin
            nxt_st.state = cdo_pkg::SM_ADDR;
            nxt_st.cnt = '0;
            nxt_st.oe = 1'b0;
        end else if (bus_stop) begin
            nxt_st.state = cdo_pkg::SM_IDLE;
            nxt_st.oe = 1'b0;
        end else begin
            case (st_ff.state)
                cdo_pkg::SM_IDLE: begin
                    nxt_st.oe = 1'b0;
                end
                cdo_pkg::SM_ADDR, cdo_pkg::SM_PTR, cdo_pkg::SM_WDATA: begin
                    // Shift in on rising clock, answer after eighth bit
                    if (scl_rise) begin
                        nxt_st.shreg = {st_ff.shreg[6:0], sda_in};
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end else if (scl_fall && st_ff.cnt == cdo_pkg::BYTE_BITS) begin
                        nxt_st.cnt = '0;
                        nxt_st.oe = 1'b1;
                        if (st_ff.state == cdo_pkg::SM_ADDR) begin
                            if (st_ff.shreg[7:1] == SLAVE_ADDR) begin
                                nxt_st.rw = st_ff.shreg[0];
                                nxt_st.state = cdo_pkg::SM_ADDR_ACK;
                            end else begin
                                nxt_st.oe = 1'b0;
                                nxt_st.state = cdo_pkg::SM_IDLE;
                            end
                        end else if (st_ff.state == cdo_pkg::SM_PTR) begin
                            nxt_st.ptr = st_ff.shreg;
                            nxt_st.state = cdo_pkg::SM_PTR_ACK;
                        end else begin
                            // Byte complete: store and advance pointer
                            case (st_ff.ptr)
                                cdo_pkg::ADR_MODE:
                                    nxt_st.mode = st_ff.shreg & cdo_pkg::MODE_MASK;
                                cdo_pkg::ADR_LSB:
                                    nxt_st.lsb = st_ff.shreg & cdo_pkg::LSB_MASK;
                                cdo_pkg::ADR_OUT0: nxt_st.out0 = st_ff.shreg;
                                cdo_pkg::ADR_CH0CTL: nxt_st.ch0ctl = st_ff.shreg;
                                cdo_pkg::ADR_OUT1: nxt_st.out1 = st_ff.shreg;
                                cdo_pkg::ADR_CH1CTL: nxt_st.ch1ctl = st_ff.shreg;
                                default: nxt_st.ptr = st_ff.ptr;
                            endcase
                            nxt_st.ptr = st_ff.ptr + 8'h01;
                            nxt_st.state = cdo_pkg::SM_WDATA_ACK;
                        end
                    end
                end
                cdo_pkg::SM_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (st_ff.rw) begin
                            nxt_st.shreg = rd_data;
                            nxt_st.oe = !rd_data[7];
                            nxt_st.ptr = st_ff.ptr + 8'h01;
                            nxt_st.state = cdo_pkg::SM_RDATA;
                        end else begin
                            nxt_st.oe = 1'b0;
                            nxt_st.state = cdo_pkg::SM_PTR;
                        end
                    end
                end
                cdo_pkg::SM_PTR_ACK, cdo_pkg::SM_WDATA_ACK: begin
                    if (scl_fall) begin
                        nxt_st.oe = 1'b0;
                        nxt_st.state = cdo_pkg::SM_WDATA;
                    end
                end
                cdo_pkg::SM_RDATA: begin
                    // Drive each bit while clock is low
                    if (scl_rise) begin
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (st_ff.cnt == cdo_pkg::BYTE_BITS) begin
                            nxt_st.oe = 1'b0;
                            nxt_st.cnt = '0;
                            nxt_st.state = cdo_pkg::SM_RACK;
                        end else begin
                            nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
                            nxt_st.oe = !st_ff.shreg[6];
                        end
                    end
                end
                cdo_pkg::SM_RACK: begin
                    // Master acknowledge continues, not-acknowledge ends
                    if (scl_rise && sda_in) begin
                        nxt_st.state = cdo_pkg::SM_IDLE;
                    end else if (scl_fall) begin
                        nxt_st.shreg = rd_data;
                        nxt_st.oe = !rd_data[7];
                        nxt_st.ptr = st_ff.ptr + 8'h01;
                        nxt_st.state = cdo_pkg::SM_RDATA;
                    end
                end
                default: begin
                    nxt_st.state = cdo_pkg::SM_IDLE;
                    nxt_st.oe = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{state: cdo_pkg::SM_IDLE, scl_q: 1'b1, sda_q: 1'b1,
                shreg: 8'h00, cnt: 4'h0, ptr: 8'h00, rw: 1'b0, oe: 1'b0,
                sda_o: 1'b0, sig: 1'b0, mode: cdo_pkg::RST_MODE,
                lsb: cdo_pkg::RST_LSB, out0: cdo_pkg::RST_OUT0,
                ch0ctl: cdo_pkg::RST_CH0CTL, out1: cdo_pkg::RST_OUT1,
                ch1ctl: cdo_pkg::RST_CH1CTL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sda_out = st_ff.sda_o;
    assign sda_oe = st_ff.oe;

    ////////////////////////////////////////////////////////////////////////
    // Field mapping onto both outputs
    always_comb begin
        ch0_cfg.force_signal_absent = st_ff.ch0ctl[cdo_pkg::B_FORCE_ABSENT];
        ch0_cfg.force_signal_present = st_ff.ch0ctl[cdo_pkg::B_FORCE_PRESENT];
        ch0_cfg.signal_gated_power_down = st_ff.ch0ctl[cdo_pkg::B_GATED_PD];
        ch0_cfg.mute_sel = st_ff.ch0ctl[cdo_pkg::B_MUTE_SEL];
        ch0_cfg.rate_select_bit = st_ff.mode[cdo_pkg::B_RATE];
        ch0_cfg.power_down = st_ff.mode[cdo_pkg::B_PD0];
        ch0_cfg.hd_thresh = {st_ff.out0[cdo_pkg::THR_HI_LSB +: cdo_pkg::THR_W],
            st_ff.lsb[cdo_pkg::B_HD_LSB]};
        ch0_cfg.sd_thresh = {st_ff.ch0ctl[cdo_pkg::THR_LO_LSB +: cdo_pkg::THR_W],
            st_ff.lsb[cdo_pkg::B_SD_LSB]};
        ch0_cfg.swing = st_ff.out0[cdo_pkg::SWING_LSB +: cdo_pkg::SWING_W];
        ch1_cfg = ch0_cfg;
        ch1_cfg.power_down = st_ff.mode[cdo_pkg::B_PD1];
        ch1_cfg.hd_thresh = {st_ff.out1[cdo_pkg::THR_HI_LSB +: cdo_pkg::THR_W],
            st_ff.ch1ctl[cdo_pkg::B_HD_LSB]};
        ch1_cfg.sd_thresh = {st_ff.ch1ctl[cdo_pkg::THR_LO_LSB +: cdo_pkg::THR_W],
            st_ff.ch1ctl[cdo_pkg::B_SD_LSB]};
        ch1_cfg.swing = st_ff.out1[cdo_pkg::SWING_LSB +: cdo_pkg::SWING_W];
    end

    // Output stage controls
    cdo_chan_ctrl u_ch0 (
        .clk(clk),
        .nrst(nrst),
        .cfg(ch0_cfg),
        .signal_present(signal_present),
        .enable_pin(enable_pin),
        .rate_pin(rate_pin),
        .out(ch0_out)
    );

    cdo_chan_ctrl u_ch1 (
        .clk(clk),
        .nrst(nrst),
        .cfg(ch1_cfg),
        .signal_present(signal_present),
        .enable_pin(enable_pin),
        .rate_pin(rate_pin),
        .out(ch1_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_STATUS_READ: assert property (@(posedge clk) disable iff (!nrst)
        st_ff.state == cdo_pkg::SM_ADDR_ACK && st_ff.rw && scl_fall && !bus_start
        && !bus_stop && st_ff.ptr == cdo_pkg::ADR_STATUS
        |=> st_ff.shreg[cdo_pkg::B_SIGNAL] == $past(signal_present, 2))
        else $error("status read not the true input state");
    AST_CH0_SD_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
        !$past(nrst) |-> ch0_cfg.sd_thresh == cdo_pkg::DEF_SD_THR)
        else $error("channel 0 slow threshold default wrong");
    AST_CH1_HD_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
        !$past(nrst) |-> ch1_cfg.hd_thresh == cdo_pkg::DEF_HD_THR)
        else $error("channel 1 fast threshold default wrong");
    AST_CH1_SWING_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
        !$past(nrst) ##1 1'b1 |-> ch1_out.swing == cdo_pkg::DEF_SWING)
        else $error("channel 1 swing default wrong");
    AST_CH1_HD_LSB: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && ch1_out.fault_threshold[0] != $past(st_ff.ch1ctl[cdo_pkg::B_HD_LSB])
        |-> $past(rate_pin || st_ff.mode[cdo_pkg::B_RATE]))
        else $error("channel 1 fast threshold low bit wrong");
    AST_CH1_SD_LSB: assert property (@(posedge clk) disable iff (!nrst)
        $past(rate_pin) |-> ch1_out.fault_threshold[0]
        == $past(st_ff.ch1ctl[cdo_pkg::B_SD_LSB]))
        else $error("channel 1 slow threshold low bit wrong");
    AST_CH1_SD_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
        !$past(nrst) |-> ch1_cfg.sd_thresh == cdo_pkg::DEF_SD_THR)
        else $error("channel 1 slow threshold default wrong");
    AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!nrst)
        st_ff.state == cdo_pkg::SM_WDATA && scl_fall && !bus_start && !bus_stop
        && st_ff.cnt == cdo_pkg::BYTE_BITS && st_ff.ptr == cdo_pkg::ADR_CH0CTL
        |=> st_ff.ch0ctl == $past(st_ff.shreg) ##2 ch0_out.mute == (
        $past(st_ff.ch0ctl[cdo_pkg::B_MUTE_SEL], 2) && $past(ch0_cfg.force_signal_absent, 2)
        && !$past(ch0_cfg.force_signal_present, 2)) || !$past(st_ff.ch0ctl[cdo_pkg::B_FORCE_ABSENT], 2))
        else $error("written control did not take effect");
    COV_WRITE: cover property (@(posedge clk) disable iff (!nrst)
        st_ff.state == cdo_pkg::SM_WDATA_ACK);
    COV_READ: cover property (@(posedge clk) disable iff (!nrst)
        st_ff.state == cdo_pkg::SM_RACK ##1 st_ff.state == cdo_pkg::SM_RDATA);
    COV_ADDR_MISS: cover property (@(posedge clk) disable iff (!nrst)
        st_ff.state == cdo_pkg::SM_ADDR ##1 st_ff.state == cdo_pkg::SM_IDLE);
endmodule
`default_nettype wire

//--- pkg/cdo_pkg.sv
`default_nettype none
package cdo_pkg;
    // Register offsets
    localparam logic [7:0] ADR_STATUS = 8'h01;
    localparam logic [7:0] ADR_MODE = 8'h02;
    localparam logic [7:0] ADR_LSB = 8'h03;
    localparam logic [7:0] ADR_OUT0 = 8'h04;
    localparam logic [7:0] ADR_CH0CTL = 8'h05;
    localparam logic [7:0] ADR_OUT1 = 8'h06;
    localparam logic [7:0] ADR_CH1CTL = 8'h07;
    // Reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_LSB = 8'hc0;
    localparam logic [7:0] RST_OUT0 = 8'h90;
    localparam logic [7:0] RST_CH0CTL = 8'h02;
    localparam logic [7:0] RST_OUT1 = 8'h90;
    localparam logic [7:0] RST_CH1CTL = 8'hda;
    // Implemented bits of the partial registers
    localparam logic [7:0] MODE_MASK = 8'he0;
    localparam logic [7:0] LSB_MASK = 8'hc0;
    // Bit positions
    localparam int B_FORCE_ABSENT = 6;
    localparam int B_FORCE_PRESENT = 5;
    localparam int B_GATED_PD = 4;
    localparam int B_MUTE_SEL = 3;
    localparam int B_RATE = 7;
    localparam int B_PD1 = 6;
    localparam int B_PD0 = 5;
    localparam int B_HD_LSB = 7;
    localparam int B_SD_LSB = 6;
    localparam int B_SIGNAL = 0;
    // Field slices
    localparam int THR_HI_LSB = 5;
    localparam int THR_LO_LSB = 0;
    localparam int THR_W = 3;
    localparam int SWING_LSB = 0;
    localparam int SWING_W = 5;
    // Combined defaults
    localparam logic [3:0] DEF_SD_THR = 4'h5;
    localparam logic [3:0] DEF_HD_THR = 4'h9;
    localparam logic [4:0] DEF_SWING = 5'h10;
    // Serial bus framing
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Per-output configuration
    typedef struct packed {
        logic force_signal_absent;
        logic force_signal_present;
        logic signal_gated_power_down;
        logic mute_sel;
        logic power_down;
        logic rate_select_bit;
        logic [3:0] hd_thresh;
        logic [3:0] sd_thresh;
        logic [4:0] swing;
    } cdo_chan_cfg_t;

    // Per-output controls to the analog stage
    typedef struct packed {
        logic mute;
        logic offset;
        logic power_down;
        logic [3:0] fault_threshold;
        logic [4:0] swing;
    } cdo_chan_out_t;

    typedef enum logic [3:0] {
        SM_IDLE, SM_ADDR, SM_ADDR_ACK, SM_PTR, SM_PTR_ACK,
        SM_WDATA, SM_WDATA_ACK, SM_RDATA, SM_RACK
    } cdo_smb_state_t;
endpackage
`default_nettype wire

//--- hdl/cdo_chan_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cdo_chan_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Configuration and pins
    input wire cdo_pkg::cdo_chan_cfg_t cfg,
    input wire logic signal_present,
    input wire logic enable_pin,
    input wire logic rate_pin,
    // Controls to the output stage
    output var cdo_pkg::cdo_chan_out_t out
);
    typedef struct packed {
        cdo_pkg::cdo_chan_out_t o;
    } cdo_chan_st_t;

    cdo_chan_st_t st_ff;
    cdo_chan_st_t nxt_st;
    logic lost;

    // Output behaviour from forcing, gating and pins
    always_comb begin
        nxt_st = st_ff;
        lost = !cfg.force_signal_present &&
            (cfg.force_signal_absent || !signal_present);
        nxt_st.o.mute = lost && cfg.mute_sel;
        nxt_st.o.offset = lost && !cfg.mute_sel;
        if (!enable_pin) begin
            nxt_st.o.power_down = 1'b1;
        end else if (cfg.signal_gated_power_down && !signal_present) begin
            nxt_st.o.power_down = 1'b1;
        end else begin
            nxt_st.o.power_down = cfg.power_down;
        end
        // Pin high forces the slow threshold
        nxt_st.o.fault_threshold = (rate_pin || cfg.rate_select_bit) ?
            cfg.sd_thresh : cfg.hd_thresh;
        nxt_st.o.swing = cfg.swing;
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign out = st_ff.o;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_FORCE_ABSENT: assert property (@(posedge clk) disable iff (!nrst)
        cfg.force_signal_absent && !cfg.force_signal_present
        |=> out.mute == $past(cfg.mute_sel) && out.offset == !$past(cfg.mute_sel))
        else $error("forced absence did not mute or offset");
    AST_FORCE_PRESENT: assert property (@(posedge clk) disable iff (!nrst)
        cfg.force_signal_present |=> !out.mute && !out.offset)
        else $error("forced presence still muted or offset");
    AST_UNGATED_PD: assert property (@(posedge clk) disable iff (!nrst)
        !cfg.signal_gated_power_down && enable_pin
        |=> out.power_down == $past(cfg.power_down))
        else $error("ungated power down not from bit");
    AST_ENABLE_LOW_PD: assert property (@(posedge clk) disable iff (!nrst)
        cfg.signal_gated_power_down && !enable_pin |=> out.power_down)
        else $error("enable low did not power down");
    AST_GATED_LOSS_PD: assert property (@(posedge clk) disable iff (!nrst)
        cfg.signal_gated_power_down && enable_pin
        |=> out.power_down == ($past(!signal_present) || $past(cfg.power_down)))
        else $error("gated power down wrong");
    AST_OFFSET_ON_LOSS: assert property (@(posedge clk) disable iff (!nrst)
        !signal_present && !cfg.force_signal_present && !cfg.mute_sel
        |=> out.offset && !out.mute)
        else $error("loss did not add offset");
    AST_MUTE_ON_LOSS: assert property (@(posedge clk) disable iff (!nrst)
        !signal_present && !cfg.force_signal_present && cfg.mute_sel
        |=> out.mute && !out.offset)
        else $error("loss did not mute");
    AST_NORMAL_RUN: assert property (@(posedge clk) disable iff (!nrst)
        signal_present && !cfg.force_signal_absent |=> !out.mute && !out.offset)
        else $error("signal present but output altered");
    AST_PD_BIT: assert property (@(posedge clk) disable iff (!nrst)
        cfg.power_down |=> out.power_down)
        else $error("power down bit ignored");
    AST_RATE_PIN: assert property (@(posedge clk) disable iff (!nrst)
        rate_pin ##1 rate_pin |-> out.fault_threshold == $past(cfg.sd_thresh))
        else $error("rate pin did not select slow threshold");
    COV_MUTE: cover property (@(posedge clk) disable iff (!nrst) !out.mute ##1 out.mute);
    COV_GATED: cover property (@(posedge clk) disable iff (!nrst)
        cfg.signal_gated_power_down && enable_pin && !signal_present ##1 out.power_down);
endmodule
`default_nettype wire

//--- bench/cdo_host.sv
`timescale 1ns/1ps
`default_nettype none
module cdo_host #(
    parameter logic [6:0] ADDR = 7'h5b
) (
    // Clock and resolved data line
    input wire logic clk,
    input wire logic sda,
    // Bus clock and data pull-down
    output var logic scl,
    output var logic sda_pull
);
    // Idle bus, both lines released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // One bit slot, data set while the bus clock is low
    task automatic slot(input logic b, output logic rb);
        sda_pull <= ~b;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        rb = sda;
        scl <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Start or repeated start
    task automatic start;
        sda_pull <= 1'b0;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_pull <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Stop, leaves the bus idle
    task automatic stop;
        sda_pull <= 1'b1;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_pull <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Byte out msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic ack);
        logic rb;
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], q[i]);
        end
        slot(last, rb);
        ack = ~rb;
    endtask
    // Pointer then one data byte
    task automatic wr(input logic [7:0] p, input logic [7:0] v, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        xfer({ADDR, 1'b0}, 1'b1, q, a0);
        xfer(p, 1'b1, q, a1);
        xfer(v, 1'b1, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // Pointer, repeated start, one byte read with a closing nack
    task automatic rd(input logic [7:0] p, output logic [7:0] v);
        logic [7:0] q;
        logic a;
        start();
        xfer({ADDR, 1'b0}, 1'b1, q, a);
        xfer(p, 1'b1, q, a);
        start();
        xfer({ADDR, 1'b1}, 1'b1, q, a);
        xfer(8'hff, 1'b1, v, a);
        stop();
    endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, nrst, en, rate, sig, scl, sda, pull, sda_out, sda_oe, ok, lost;
    logic [2:0] ex;
    logic [7:0] q;
    logic [7:0] vals [8] = '{8'h02, 8'h0a, 8'h42, 8'h4a, 8'h22, 8'h62, 8'h12, 8'h5a};
    cdo_pkg::cdo_chan_out_t o0, o1;
    int bad_count, checks_done;
    // Open-drain data line with pull-up
    assign sda = ~(pull | (sda_oe & ~sda_out));
    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    cdo_host host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
    cdo_output_ctrl_regs uut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(en), .rate_pin(rate),
        .signal_present(sig), .ch0_out(o0), .ch1_out(o1));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] p, input logic [7:0] v);
        host.wr(p, v, ok);
        chk(ok, 1'b1);
        repeat (3) @(posedge clk);
    endtask
    task automatic r(input logic [7:0] p);
        host.rd(p, q);
    endtask
    task automatic pins(input logic s, input logic e, input logic rs);
        sig <= s;
        en <= e;
        rate <= rs;
        repeat (3) @(posedge clk);
    endtask
    task automatic conclude;
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #3000000;
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        nrst = 1'b0;
        {en, rate, sig} = 3'b101;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        r(8'h05); chk(q, 8'h02);
        r(8'h06); chk(q, 8'h90);
        r(8'h07); chk(q, 8'hda);
        chk({o1.fault_threshold, o1.swing}, {4'h9, 5'h10});
        chk({o0.fault_threshold, o0.swing}, {4'h9, 5'h10});
        pins(1'b1, 1'b1, 1'b1);
        chk({o0.fault_threshold, o1.fault_threshold}, 8'h55);
        w(8'h06, 8'h3a);
        r(8'h06); chk(q, 8'h3a);
        pins(1'b1, 1'b1, 1'b0);
        chk({o1.fault_threshold, o1.swing}, {4'h3, 5'h1a});
        w(8'h07, 8'h5d);
        r(8'h07); chk(q, 8'h5d);
        chk(o1.fault_threshold, 4'h2);
        pins(1'b1, 1'b1, 1'b1);
        chk(o1.fault_threshold, 4'hb);
        pins(1'b1, 1'b1, 1'b0);
        w(8'h02, 8'h80);
        chk(o1.fault_threshold, 4'hb);
        w(8'h02, 8'h40);
        chk({o0.power_down, o1.power_down}, 2'b01);
        pins(1'b1, 1'b0, 1'b0);
        chk({o0.power_down, o1.power_down}, 2'b11);
        w(8'h02, 8'h00);
        r(8'h20); chk(q, 8'h00);
        foreach (vals[i]) begin
            w(8'h05, vals[i]);
            for (int k = 0; k < 4; k++) begin
                pins(k[0], k[1], 1'b0);
                lost = !vals[i][5] && (vals[i][6] || !k[0]);
                ex = {lost && vals[i][3], lost && !vals[i][3], !k[1] || (vals[i][4] && !k[0])};
                chk({o0.mute, o0.offset, o0.power_down}, ex);
                chk({o1.mute, o1.offset, o1.power_down}, ex);
                r(8'h01); chk(q[0], k[0]);
            end
        end
        conclude();
    end
endmodule
`default_nettype wire
